//--- common/ecst_defs.svh
/*
 Register offsets, field positions, reset values and sizes of the
 extension context status tracker. Assumes inclusion by bare name.
*/
`ifndef ECST_DEFS_SVH
`define ECST_DEFS_SVH

`define ECST_ADDR_W          8
`define ECST_UNITS           3
`define ECST_CTX_OFF         8'h00
`define ECST_EXT_OFF         8'h04
`define ECST_IRQ_STAT_OFF    8'h08
`define ECST_IRQ_MASK_OFF    8'h0C
`define ECST_CFG_OFF         8'h10
`define ECST_SEL_CTX         3'h0
`define ECST_SEL_EXT         3'h1
`define ECST_SEL_STAT        3'h2
`define ECST_SEL_MASK        3'h3
`define ECST_SEL_CFG         3'h4
`define ECST_SEL_NONE        3'h7
`define ECST_CTX_FS_LSB      0
`define ECST_CTX_XS_LSB      2
`define ECST_CTX_SD_BIT      31
`define ECST_IRQ_W           2
`define ECST_IRQ_ILLEGAL_BIT 0
`define ECST_IRQ_DIRTY_BIT   1
`define ECST_CFG_TRACK_BIT   0
`define ECST_CFG_RESET       1'h1
`define ECST_RESP_OKAY       2'h0
`define ECST_RESP_SLVERR     2'h2

`endif

//--- common/ecst_pkg.sv
/*
 Types of the extension context status tracker: status encoding and
 execution operations. Assumes nothing of its surroundings.
*/
`default_nettype none
package ecst_pkg;
    typedef enum logic [1:0] {
        ST_OFF   = 2'h0,
        ST_INIT  = 2'h1,
        ST_CLEAN = 2'h2,
        ST_DIRTY = 2'h3
    } ecst_status_e;
    typedef enum logic [2:0] {
        OP_READ     = 3'h0,
        OP_MODIFY   = 3'h1,
        OP_UNCONFIG = 3'h3,
        OP_DISABLE  = 3'h2,
        OP_ENABLE   = 3'h6
    } ecst_op_e;
endpackage
`default_nettype wire

//--- common/ecst_unit_if.sv
/*
 Link between the tracker top and one unit status machine.
 Assumes one driver of each side, on the same clock.
*/
`default_nettype none
interface ecst_unit_if;
    logic                   op_valid;
    ecst_pkg::ecst_op_e     op;
    logic                   sw_we;
    logic [1:0]             sw_val;
    logic                   present;
    logic                   track_dirty;
    ecst_pkg::ecst_status_e status;
    logic                   illegal;
    logic                   turn_on;
    modport unit (input op_valid, op, sw_we, sw_val, present, track_dirty,
                  output status, illegal, turn_on);
    modport ctrl (output op_valid, op, sw_we, sw_val, present, track_dirty,
                  input status, illegal, turn_on);
endinterface
`default_nettype wire

//--- src/ecst_top.sv
/*
 Extension context status tracker: floating-point status, extension
 summary and dirty summary, AXI4-Lite registers, one interrupt.
 Assumes the execution pipeline presents at most one unit operation
 per cycle and an AXI4-Lite master with one access of each kind.
*/
// Operation
// - Two-bit writable floating-point status covering fp control and data registers.
// - Encoding 0 Off, 1 Initial, 2 Clean, 3 Dirty for both fields.
// - Floating-point status reads zero without supervisor mode and fp unit.
// - Extension summary reads zero without stateful extensions, else read-only.
// - Extension summary is the maximum of all extension status fields.
// - Dirty summary is one exactly when either field equals three.
// - Off status traps read, modify and unconfigure of the unit and stays Off.
// - Modify moves Initial or Clean to Dirty; read leaves status alone.
// - Unconfigure gives Initial, disable gives Off, enable gives Initial; the fp unit traps all three.
// - Turning a unit on requests initialisation of its state.
// - Writing fp status never touches the fp register contents.
// - Without dirty tracking, Initial or Clean writes are stored as Dirty.
// - Software writes fp status directly; summary only via extension fields.
// - One copy of both fields, shared by all privilege modes.
`default_nettype none
`include "ecst_defs.svh"
module ecst_top #(
    parameter bit FP_PRESENT    = 1'b1,
    parameter bit SMODE_PRESENT = 1'b1,
    parameter bit EXT_PRESENT   = 1'b1
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic [`ECST_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [`ECST_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic                     exec_valid,
    input  wire logic [1:0]               exec_unit,
    input  wire logic [2:0]               exec_op,
    output logic                          exec_illegal,
    output logic [`ECST_UNITS-1:0]        exec_init_req,
    output logic [1:0]                    fp_context_status,
    output logic [1:0]                    extension_context_summary,
    output logic                          dirty_state_summary,
    output logic                          irq
);
    logic [`ECST_ADDR_W-1:0]  aw_addr;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     wr_do;
    logic [2:0]               wr_sel;
    logic [2:0]               rd_sel;
    logic                     wr_lo;
    logic [31:0]              rd_word;
    logic                     ar_fire;
    logic [`ECST_UNITS-1:0]   unit_we;
    logic [1:0]               unit_val [`ECST_UNITS];
    logic [`ECST_UNITS-1:0]   unit_present;
    logic [`ECST_UNITS-1:0]   unit_track;
    logic [`ECST_UNITS-1:0]   ill_vec;
    logic [`ECST_UNITS-1:0]   on_vec;
    logic [1:0]               st_vec [`ECST_UNITS];
    logic                     unit_miss;
    logic                     any_illegal;
    logic [1:0]               fs_now;
    logic [1:0]               xs_now;
    logic                     sd_now;
    logic                     cfg_track;
    logic [`ECST_IRQ_W-1:0]   irq_stat;
    logic [`ECST_IRQ_W-1:0]   irq_mask;
    logic [`ECST_IRQ_W-1:0]   irq_evt;
    logic [`ECST_IRQ_W-1:0]   irq_clr;
    logic [`ECST_IRQ_W-1:0]   next_irq_stat;

    function automatic logic [2:0] reg_sel(input logic [`ECST_ADDR_W-1:0] a);
        case ({a[`ECST_ADDR_W-1:2], 2'h0})
            `ECST_CTX_OFF:      reg_sel = `ECST_SEL_CTX;
            `ECST_EXT_OFF:      reg_sel = `ECST_SEL_EXT;
            `ECST_IRQ_STAT_OFF: reg_sel = `ECST_SEL_STAT;
            `ECST_IRQ_MASK_OFF: reg_sel = `ECST_SEL_MASK;
            `ECST_CFG_OFF:      reg_sel = `ECST_SEL_CFG;
            default:            reg_sel = `ECST_SEL_NONE;
        endcase
    endfunction

    function automatic logic [1:0] status_max(input logic [1:0] a, input logic [1:0] b);
        // Rank by meaning, not by code: Off < Initial < Clean < Dirty
        status_max = (a == 2'h3 || b == 2'h3) ? 2'h3
                   : (a == 2'h2 || b == 2'h2) ? 2'h2
                   : (a == 2'h1 || b == 2'h1) ? 2'h1 : 2'h0;
    endfunction

    // Write path: address and data are held until both have arrived
    assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_sel = reg_sel(aw_addr);
    assign wr_lo = wr_do && w_strb[0];
    assign rd_sel = reg_sel(s_axi_araddr);
    assign ar_fire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            aw_addr       <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_wready <= 1'b1;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ECST_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == `ECST_SEL_NONE) ? `ECST_RESP_SLVERR : `ECST_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        case (rd_sel)
            `ECST_SEL_CTX: begin
                rd_word[`ECST_CTX_FS_LSB +: 2] = fs_now;
                rd_word[`ECST_CTX_XS_LSB +: 2] = xs_now;
                rd_word[`ECST_CTX_SD_BIT]      = sd_now;
            end
            `ECST_SEL_EXT:  rd_word[3:0] = {st_vec[2], st_vec[1]};
            `ECST_SEL_STAT: rd_word[`ECST_IRQ_W-1:0] = irq_stat;
            `ECST_SEL_MASK: rd_word[`ECST_IRQ_W-1:0] = irq_mask;
            `ECST_SEL_CFG:  rd_word[`ECST_CFG_TRACK_BIT] = cfg_track;
            default:        rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ECST_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_sel == `ECST_SEL_NONE) ? `ECST_RESP_SLVERR : `ECST_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // No path from these writes to fp registers
    assign unit_we[0] = wr_lo && (wr_sel == `ECST_SEL_CTX);
    assign unit_we[1] = wr_lo && (wr_sel == `ECST_SEL_EXT);
    assign unit_we[2] = wr_lo && (wr_sel == `ECST_SEL_EXT);
    assign unit_val[0] = w_data[`ECST_CTX_FS_LSB +: 2];
    assign unit_val[1] = w_data[1:0];
    assign unit_val[2] = w_data[3:2];
    // Fp field absent only without both
    assign unit_present[0] = FP_PRESENT || SMODE_PRESENT;
    assign unit_present[1] = EXT_PRESENT;
    assign unit_present[2] = EXT_PRESENT;
    assign unit_track[0] = cfg_track;
    assign unit_track[2:1] = 2'h3;

    ecst_unit_if u_if [`ECST_UNITS] ();
    genvar gi;
    generate
        for (gi = 0; gi < `ECST_UNITS; gi++) begin : g_unit
            assign u_if[gi].op_valid    = exec_valid && (exec_unit == 2'(gi));
            assign u_if[gi].op          = ecst_pkg::ecst_op_e'(exec_op);
            assign u_if[gi].sw_we       = unit_we[gi];
            assign u_if[gi].sw_val      = unit_val[gi];
            assign u_if[gi].present     = unit_present[gi];
            assign u_if[gi].track_dirty = unit_track[gi];
            assign ill_vec[gi]          = u_if[gi].illegal;
            assign on_vec[gi]           = u_if[gi].turn_on;
            assign st_vec[gi]           = u_if[gi].status;
            ecst_unit #(
                .CAN_SWITCH (gi != 0)
            ) u_unit (
                .clk  (clk),
                .nrst (nrst),
                .u    (u_if[gi])
            );
        end
    endgenerate

    assign fs_now = st_vec[0];
    assign xs_now = status_max(st_vec[1], st_vec[2]);
    assign sd_now = (fs_now == 2'h3) || (xs_now == 2'h3);
    assign unit_miss = exec_valid && (exec_unit >= 2'(`ECST_UNITS));
    assign any_illegal = (|ill_vec) || unit_miss;

    // Pins lag the register view by one cycle so they leave from flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fp_context_status         <= 2'h0;
            extension_context_summary <= 2'h0;
            dirty_state_summary       <= 1'b0;
            exec_illegal              <= 1'b0;
            exec_init_req             <= 3'h0;
        end else begin
            fp_context_status         <= fs_now;
            extension_context_summary <= xs_now;
            dirty_state_summary       <= sd_now;
            exec_illegal              <= any_illegal;
            exec_init_req             <= on_vec;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_track <= `ECST_CFG_RESET;
            irq_mask  <= 2'h0;
        end else if (wr_lo && wr_sel == `ECST_SEL_CFG) begin
            cfg_track <= w_data[`ECST_CFG_TRACK_BIT];
        end else if (wr_lo && wr_sel == `ECST_SEL_MASK) begin
            irq_mask  <= w_data[`ECST_IRQ_W-1:0];
        end
    end

    // Sticky events; a new event wins over a write-one clear
    assign irq_evt[`ECST_IRQ_ILLEGAL_BIT] = any_illegal;
    assign irq_evt[`ECST_IRQ_DIRTY_BIT]   = sd_now && !dirty_state_summary;
    assign irq_clr = (wr_lo && wr_sel == `ECST_SEL_STAT) ? w_data[`ECST_IRQ_W-1:0] : 2'h0;
    assign next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat <= 2'h0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq      <= |(next_irq_stat & irq_mask);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sd_pin_a: assert property (
        ##1 dirty_state_summary == ($past(fs_now) == 2'h3 || $past(xs_now) == 2'h3))
        else $error("Dirty summary pin wrong");
    xs_max_a: assert property (
        (xs_now == st_vec[1] || xs_now == st_vec[2])
        && (st_vec[1] != 2'h3 || xs_now == 2'h3) && (st_vec[2] != 2'h3 || xs_now == 2'h3))
        else $error("Extension summary is not the maximum");
    xs_zero_a: assert property (
        !EXT_PRESENT |-> xs_now == 2'h0 && extension_context_summary == 2'h0)
        else $error("Summary nonzero without extensions");
    fs_zero_a: assert property (
        !FP_PRESENT && !SMODE_PRESENT |-> fs_now == 2'h0)
        else $error("Fp status nonzero when absent");
    fs_write_a: assert property (
        unit_we[0] && !exec_valid && cfg_track && unit_present[0]
        |=> fs_now == $past(unit_val[0]))
        else $error("Fp status write not stored");
    reset_off_a: assert property (
        $past(!nrst) |-> fp_context_status == 2'h0 && !dirty_state_summary)
        else $error("Not Off after reset");
    illegal_pulse_a: assert property (
        exec_valid && exec_unit == 2'h0 && fs_now == 2'h0 && exec_op == 3'h1
        |=> exec_illegal ##1 fp_context_status == 2'h0)
        else $error("Fp use while Off not trapped");
    write_resp_a: assert property (
        wr_do |=> s_axi_bvalid)
        else $error("Write response missing");
    irq_c: cover property (irq ##1 !irq);
    read_c: cover property (ar_fire ##1 s_axi_rvalid);
    dirty_c: cover property (!dirty_state_summary ##1 dirty_state_summary);
endmodule
`default_nettype wire

//--- src/ecst_unit.sv
/*
 Status machine of one unit: Off, Initial, Clean, Dirty.
 Assumes at most one operation per cycle from the top.
*/
`default_nettype none
module ecst_unit #(
    parameter bit CAN_SWITCH = 1'b1
) (
    input  wire logic  clk,
    input  wire logic  nrst,
    ecst_unit_if.unit  u
);
    ecst_pkg::ecst_status_e status;
    ecst_pkg::ecst_status_e next_status;
    ecst_pkg::ecst_status_e op_result;
    logic                   switch_op;
    logic                   op_ok;

    function automatic ecst_pkg::ecst_status_e legalise(
        input ecst_pkg::ecst_status_e v, input logic track);
        legalise = (!track && (v == ecst_pkg::ST_INIT || v == ecst_pkg::ST_CLEAN))
                 ? ecst_pkg::ST_DIRTY : v;
    endfunction

    assign switch_op = (u.op == ecst_pkg::OP_UNCONFIG) || (u.op == ecst_pkg::OP_DISABLE)
                    || (u.op == ecst_pkg::OP_ENABLE);
    assign u.illegal = u.op_valid && (!u.present || (switch_op && !CAN_SWITCH)
                     || (status == ecst_pkg::ST_OFF && (u.op == ecst_pkg::OP_READ
                     || u.op == ecst_pkg::OP_MODIFY || u.op == ecst_pkg::OP_UNCONFIG)));
    assign op_ok = u.op_valid && !u.illegal;
    assign u.turn_on = op_ok && (u.op == ecst_pkg::OP_ENABLE);

    always_comb begin
        case (u.op)
            ecst_pkg::OP_READ:     op_result = status;
            ecst_pkg::OP_MODIFY:   op_result = ecst_pkg::ST_DIRTY;
            ecst_pkg::OP_UNCONFIG: op_result = ecst_pkg::ST_INIT;
            ecst_pkg::OP_DISABLE:  op_result = ecst_pkg::ST_OFF;
            ecst_pkg::OP_ENABLE:   op_result = ecst_pkg::ST_INIT;
            default:               op_result = status;
        endcase
    end

    // Untracked stores dirty
    // Instruction update beats a software write in the same cycle
    // Unchanged result keeps status, so a read never marks an untracked unit dirty
    assign next_status = !u.present ? ecst_pkg::ST_OFF
                       : (op_ok && op_result == status) ? status
                       : op_ok ? legalise(op_result, u.track_dirty)
                       : u.sw_we ? legalise(ecst_pkg::ecst_status_e'(u.sw_val), u.track_dirty)
                       : status;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status <= ecst_pkg::ST_OFF;
        end else begin
            status <= next_status;
        end
    end
    assign u.status = status;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    off_trap_a: assert property (
        u.op_valid && status == ecst_pkg::ST_OFF && !u.sw_we && (u.op == ecst_pkg::OP_READ
        || u.op == ecst_pkg::OP_MODIFY || u.op == ecst_pkg::OP_UNCONFIG)
        |-> u.illegal ##1 status == ecst_pkg::ST_OFF)
        else $error("Off unit was used without a trap");
    modify_dirty_a: assert property (
        u.op_valid && u.present && u.op == ecst_pkg::OP_MODIFY
        && status != ecst_pkg::ST_OFF |=> status == ecst_pkg::ST_DIRTY)
        else $error("Modify did not mark dirty");
    read_keep_a: assert property (
        u.op_valid && u.present && u.op == ecst_pkg::OP_READ && !u.sw_we |=> $stable(status))
        else $error("Read changed status");
    enable_init_a: assert property (
        u.op_valid && u.present && CAN_SWITCH && u.track_dirty
        && u.op == ecst_pkg::OP_ENABLE |=> status == ecst_pkg::ST_INIT)
        else $error("Enable did not give Initial");
    disable_off_a: assert property (
        u.op_valid && u.present && CAN_SWITCH && u.op == ecst_pkg::OP_DISABLE
        |=> status == ecst_pkg::ST_OFF)
        else $error("Disable did not give Off");
    untracked_dirty_a: assert property (
        u.present && !u.track_dirty && u.sw_we && !u.op_valid
        && u.sw_val != 2'h0 |=> status == ecst_pkg::ST_DIRTY)
        else $error("Untracked write not stored as Dirty");
    modify_c: cover property (u.op_valid && u.op == ecst_pkg::OP_MODIFY
        && status == ecst_pkg::ST_CLEAN ##1 status == ecst_pkg::ST_DIRTY);
    enable_c: cover property (u.turn_on && status == ecst_pkg::ST_OFF);
endmodule
`default_nettype wire

//--- tb/ecst_exec_model.sv
/*
 Execution pipeline model: issues one unit operation per call.
 Assumes the tracker samples exec_valid at the rising clk edge.
*/
`default_nettype none
module ecst_exec_model (
    input  wire logic       clk,
    output logic            exec_valid,
    output logic [1:0]      exec_unit,
    output logic [2:0]      exec_op,
    input  wire logic       exec_illegal,
    input  wire logic [2:0] exec_init_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        exec_valid = 1'h0;
        exec_unit = 2'h3;
        exec_op = 3'h7;
    end
    // Unit and op flipped after release so stale values never look valid
    task automatic issue(input logic [1:0] u, input logic [2:0] o,
                         output logic ill, output logic [2:0] ini);
        @(posedge clk);
        exec_valid <= 1'h1;
        exec_unit <= u;
        exec_op <= o;
        @(posedge clk);
        exec_valid <= 1'h0;
        exec_unit <= ~u;
        exec_op <= ~o;
        @(negedge clk);
        ill = exec_illegal;
        ini = exec_init_req;
    endtask
endmodule
`default_nettype wire

//--- tb/tb_extension_context_status_tracker.sv
/*
 Bench of the tracker: AXI4-Lite register tasks and exec operations.
 Assumes the tracker's hand-over timing; nothing else.
*/
`default_nettype none
module tb_extension_context_status_tracker;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, exec_valid, exec_illegal, dirty_state_summary, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, exec_unit, fp_context_status;
    logic [1:0]  extension_context_summary;
    logic [2:0]  exec_op, exec_init_req;
    int          mismatches, checked;
    ecst_top ecst_top_inst (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_valid, .exec_unit,
        .exec_op, .exec_illegal, .exec_init_req, .fp_context_status,
        .extension_context_summary, .dirty_state_summary, .irq);
    ecst_exec_model ecst_exec_model_inst (.clk, .exec_valid, .exec_unit, .exec_op,
        .exec_illegal, .exec_init_req);
    task automatic close_out;
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic aw, w, b;
        logic [1:0] r;
        b = 1'h0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n < 40 && !b; n++) begin
            @(negedge clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (b) s_axi_bready <= 1'h0;
        end
        if (!b) begin
            mismatches++;
            close_out();
        end
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        logic ar, rv;
        logic [1:0] r;
        logic [31:0] d;
        rv = 1'h0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n < 40 && !rv; n++) begin
            @(negedge clk);
            ar = s_axi_arvalid & s_axi_arready;
            rv = s_axi_rvalid;
            r = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'h0;
            if (rv) s_axi_rready <= 1'h0;
        end
        if (!rv) begin
            mismatches++;
            close_out();
        end
        chk("rresp", {30'h0, er}, {30'h0, r});
        if (er == 2'h0) chk("rdata", e, d);
    endtask
    task automatic ex(input logic [1:0] u, input logic [2:0] o, input logic ei,
                      input logic [2:0] eq = 3'h0);
        logic ill;
        logic [2:0] ini;
        ecst_exec_model_inst.issue(u, o, ill, ini);
        chk("exec_illegal", {31'h0, ei}, {31'h0, ill});
        chk("exec_init_req", {29'h0, eq}, {29'h0, ini});
    endtask
    task automatic pins(input logic [4:0] e);
        @(negedge clk);
        chk("pins", {27'h0, e}, {27'h0, dirty_state_summary, extension_context_summary,
            fp_context_status});
    endtask
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        rd(8'h00, 32'h0);
        pins(5'h00);
        ex(2'h0, ecst_pkg::OP_MODIFY, 1'h1);
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h1);
        wr(8'h0C, 32'h1);
        pins(5'h00);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h08, 32'h1);
        rd(8'h08, 32'h0);
        pins(5'h00);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'h1);
        ex(2'h0, ecst_pkg::OP_READ, 1'h0);
        rd(8'h00, 32'h1);
        ex(2'h0, ecst_pkg::OP_MODIFY, 1'h0);
        rd(8'h00, 32'h80000003);
        pins(5'h13);
        rd(8'h08, 32'h2);
        // Save path: only Dirty state is stored, then marked Clean
        wr(8'h00, 32'h2);
        rd(8'h00, 32'h2);
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h80000003);
        wr(8'h10, 32'h1);
        // Restore of an Initial context needs no memory access
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h1);
        wr(8'h00, 32'h0000000C);
        rd(8'h00, 32'h0);
        wr(8'h04, 32'h9);
        rd(8'h00, 32'h8);
        ex(2'h1, ecst_pkg::OP_MODIFY, 1'h0);
        rd(8'h00, 32'h8000000C);
        pins(5'h1C);
        ex(2'h1, ecst_pkg::OP_UNCONFIG, 1'h0);
        ex(2'h2, ecst_pkg::OP_DISABLE, 1'h0);
        rd(8'h04, 32'h1);
        ex(2'h2, ecst_pkg::OP_DISABLE, 1'h0);
        ex(2'h2, ecst_pkg::OP_READ, 1'h1);
        ex(2'h2, ecst_pkg::OP_ENABLE, 1'h0, 3'h4);
        rd(8'h04, 32'h5);
        rd(8'h00, 32'h4);
        ex(2'h0, ecst_pkg::OP_ENABLE, 1'h1);
        ex(2'h3, ecst_pkg::OP_READ, 1'h1);
        rd(8'h14, 32'h0, 2'h2);
        wr(8'h14, 32'h3, 2'h2);
        close_out();
    end
endmodule
`default_nettype wire
